// file: hdl/dcf_pkg.sv
`default_nettype none
package dcf_pkg;

  localparam int unsigned DATA_W           = 36;
  localparam int unsigned DEPTH_2K         = 2048;
  localparam int unsigned DEPTH_4K         = 4096;
  localparam int unsigned DEPTH_8K         = 8192;
  localparam int unsigned DEFAULT_DEPTH    = DEPTH_2K;
  localparam int unsigned FLAG_SYNC_STAGES = 2;
  localparam logic        MAIL_FLAG_RESET  = 1'b1;
  localparam logic        OUT_READY_RESET  = 1'b0;
  localparam logic [DATA_W-1:0] DATA_RESET = 36'h0_0000_0000;

  typedef struct packed {
    logic select_n;
    logic dir;
    logic enable;
    logic mailbox_sel;
  } dcf_port_ctrl_t;

endpackage
`default_nettype wire

// file: hdl/dcf_sync_chain.sv
`timescale 1ns/1ps
`default_nettype none
module dcf_sync_chain
#(
  parameter int unsigned WIDTH  = 14,
  parameter int unsigned STAGES = dcf_pkg::FLAG_SYNC_STAGES
)
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  import dcf_pkg::*;

  logic [WIDTH-1:0] stage      [STAGES];
  logic [WIDTH-1:0] next_stage [STAGES];

  generate
    if (STAGES < 2)
    begin : g_bad_stages
      $error("dcf_sync_chain needs at least two stages");
    end
  endgenerate

  always_comb
  begin
    next_stage[0] = din;
    for (int i = 1; i < STAGES; i++)
    begin
      next_stage[i] = stage[i-1];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < STAGES; i++)
      begin
        stage[i] <= '0;
      end
    end
    else
    begin
      stage <= next_stage;
    end
  end

  assign dout = stage[STAGES-1];
endmodule
`default_nettype wire

// file: hdl/dcf_mailbox.sv
`timescale 1ns/1ps
`default_nettype none
module dcf_mailbox
(
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      write_req,
  input  wire logic                      read_req,
  input  wire logic [dcf_pkg::DATA_W-1:0] wdata,
  output logic      [dcf_pkg::DATA_W-1:0] rdata,
  output logic                           flag_n
);
  import dcf_pkg::*;

  logic [DATA_W-1:0] mail;
  logic [DATA_W-1:0] next_mail;
  logic              flag;
  logic              next_flag;

  always_comb
  begin
    next_mail = mail;
    next_flag = flag;
    if (read_req)
    begin
      next_flag = 1'b1;
    end
    // Writes only land while the box is empty
    if (write_req && flag)
    begin
      next_mail = wdata;
      next_flag = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mail <= DATA_RESET;
      flag <= MAIL_FLAG_RESET;
    end
    else
    begin
      mail <= next_mail;
      flag <= next_flag;
    end
  end

  assign rdata  = mail;
  assign flag_n = flag;
endmodule
`default_nettype wire

// file: hdl/dcf_top.sv
`timescale 1ns/1ps
`default_nettype none
module dcf_top
#(
  parameter int unsigned DEPTH = dcf_pkg::DEFAULT_DEPTH,
  parameter int unsigned AW    = $clog2(DEPTH)
)
(
  input  wire logic                    SYS_CLK,
  input  wire logic                    SYS_RST,
  input  wire logic                    FALL_THROUGH_MODE,
  input  wire logic [AW-1:0]           ALMOST_EMPTY_OFFSET,
  input  wire logic [AW-1:0]           ALMOST_FULL_OFFSET,
  input  wire dcf_pkg::dcf_port_ctrl_t WRITE_PORT_CTRL,
  input  wire logic [dcf_pkg::DATA_W-1:0] WRITE_PORT_DATA_IN,
  output logic      [dcf_pkg::DATA_W-1:0] WRITE_PORT_DATA_OUT,
  output logic                         WRITE_PORT_DATA_OE_N,
  input  wire dcf_pkg::dcf_port_ctrl_t READ_PORT_CTRL,
  input  wire logic [dcf_pkg::DATA_W-1:0] READ_PORT_DATA_IN,
  output logic      [dcf_pkg::DATA_W-1:0] READ_PORT_DATA_OUT,
  output logic                         READ_PORT_DATA_OE_N,
  output logic                         FULL_OR_IN_READY,
  output logic                         ALMOST_FULL_N,
  output logic                         EMPTY_OR_OUT_READY,
  output logic                         ALMOST_EMPTY_N,
  output logic                         A_TO_B_MAIL_FLAG_N,
  output logic                         B_TO_A_MAIL_FLAG_N
);
  import dcf_pkg::*;

  // Fill value that means every location is taken
  localparam logic [AW:0] DEPTH_WORDS = (AW+1)'(DEPTH);

  // Memory fill as seen by the read side
  typedef enum logic [1:0]
  {
    FILL_EMPTY = 2'b00,
    FILL_ONE   = 2'b01,
    FILL_TWO   = 2'b10,
    FILL_MORE  = 2'b11
  } dcf_fill_state_t;

  generate
    if (!(DEPTH == DEPTH_2K || DEPTH == DEPTH_4K || DEPTH == DEPTH_8K)
        || (AW != $clog2(DEPTH)))
    begin : g_bad_depth
      $error("dcf_top depth must be 2048, 4096 or 8192 words");
    end
    if (FLAG_SYNC_STAGES < 2)
    begin : g_bad_sync
      $error("dcf_top flags need two synchroniser stages");
    end
  endgenerate

  logic [DATA_W-1:0] mem [DEPTH];

  logic [AW:0]       wr_ptr;
  logic [AW:0]       next_wr_ptr;
  logic [AW:0]       rd_ptr;
  logic [AW:0]       next_rd_ptr;
  logic [AW:0]       wr_ptr_at_rd;
  logic [AW:0]       rd_ptr_at_wr;
  logic [AW:0]       fill_rd;
  logic [AW:0]       fill_wr;
  logic [DATA_W-1:0] out_reg;
  logic [DATA_W-1:0] next_out_reg;
  logic              out_ready;
  logic              next_out_ready;

  logic              a_sel;
  logic              a_fifo_write;
  logic              a_mail_write;
  logic              a_mail_read;
  logic              b_sel;
  logic              b_fifo_read_sel;
  logic              b_mail_write;
  logic              b_mail_read;
  logic              mem_has_word;
  logic              empty_n_std;
  logic              read_ok;
  logic              load_out;
  dcf_fill_state_t   fill_state;
  logic [DATA_W-1:0] a_to_b_data;
  logic [DATA_W-1:0] b_to_a_data;

  // Port decode; with enable low no FIFO or mailbox access happens, but output drive still follows select/dir
  assign a_sel = !WRITE_PORT_CTRL.select_n && WRITE_PORT_CTRL.enable;
  assign b_sel = !READ_PORT_CTRL.select_n && READ_PORT_CTRL.enable;

  always_comb
  begin
    a_fifo_write = 1'b0;
    a_mail_write = 1'b0;
    a_mail_read  = 1'b0;
    if (a_sel)
    begin
      case ({WRITE_PORT_CTRL.dir, WRITE_PORT_CTRL.mailbox_sel})
        2'b10:   a_fifo_write = FULL_OR_IN_READY;
        2'b11:   a_mail_write = 1'b1;
        2'b01:   a_mail_read  = 1'b1;
        // Port A read of the FIFO side has no function
        default: a_fifo_write = 1'b0;
      endcase
    end
  end

  always_comb
  begin
    b_fifo_read_sel = 1'b0;
    b_mail_write    = 1'b0;
    b_mail_read     = 1'b0;
    if (b_sel)
    begin
      case ({READ_PORT_CTRL.dir, READ_PORT_CTRL.mailbox_sel})
        2'b10:   b_fifo_read_sel = 1'b1;
        2'b11:   b_mail_read     = 1'b1;
        2'b01:   b_mail_write    = 1'b1;
        // Port B input to the FIFO side has no function
        default: b_fifo_read_sel = 1'b0;
      endcase
    end
  end

  // Output drive follows select and dir directly, not the clock
  assign WRITE_PORT_DATA_OE_N = WRITE_PORT_CTRL.select_n || WRITE_PORT_CTRL.dir;
  assign WRITE_PORT_DATA_OUT  = b_to_a_data;
  assign READ_PORT_DATA_OE_N  = READ_PORT_CTRL.select_n || !READ_PORT_CTRL.dir;
  assign READ_PORT_DATA_OUT   = READ_PORT_CTRL.mailbox_sel ? a_to_b_data : out_reg;

  // Mailboxes bypass the FIFO in each direction
  dcf_mailbox u_a_to_b
  (
    .clk       (SYS_CLK),
    .rst       (SYS_RST),
    .write_req (a_mail_write),
    .read_req  (b_mail_read),
    .wdata     (WRITE_PORT_DATA_IN),
    .rdata     (a_to_b_data),
    .flag_n    (A_TO_B_MAIL_FLAG_N)
  );

  dcf_mailbox u_b_to_a
  (
    .clk       (SYS_CLK),
    .rst       (SYS_RST),
    .write_req (b_mail_write),
    .read_req  (a_mail_read),
    .wdata     (READ_PORT_DATA_IN),
    .rdata     (b_to_a_data),
    .flag_n    (B_TO_A_MAIL_FLAG_N)
  );

  // Pointers cross through two stages; an edge too close to the update
  // simply sees the old value, deferring the first sync cycle
  dcf_sync_chain #(.WIDTH(AW+1), .STAGES(FLAG_SYNC_STAGES)) u_wr_to_rd
  (
    .clk  (SYS_CLK),
    .rst  (SYS_RST),
    .din  (wr_ptr),
    .dout (wr_ptr_at_rd)
  );

  dcf_sync_chain #(.WIDTH(AW+1), .STAGES(FLAG_SYNC_STAGES)) u_rd_to_wr
  (
    .clk  (SYS_CLK),
    .rst  (SYS_RST),
    .din  (rd_ptr),
    .dout (rd_ptr_at_wr)
  );

  // Fill excludes the output register since rd_ptr moves on each load
  assign fill_rd      = wr_ptr_at_rd - rd_ptr;
  assign fill_wr      = wr_ptr - rd_ptr_at_wr;
  assign empty_n_std  = mem_has_word;

  // Empty, empty+1 and empty+2 told apart from the synced pointers
  always_comb
  begin
    case (fill_rd)
      (AW+1)'(0): fill_state = FILL_EMPTY;
      (AW+1)'(1): fill_state = FILL_ONE;
      (AW+1)'(2): fill_state = FILL_TWO;
      default:    fill_state = FILL_MORE;
    endcase
  end
  assign mem_has_word = (fill_state != FILL_EMPTY);

  // Read acceptance: ignored while the mode's flag is low
  assign read_ok  = b_fifo_read_sel && (FALL_THROUGH_MODE ? out_ready : empty_n_std);
  assign load_out = FALL_THROUGH_MODE
                    ? (mem_has_word && (!out_ready || b_fifo_read_sel))
                    : read_ok;

  // Write side state
  always_comb
  begin
    next_wr_ptr = wr_ptr;
    if (a_fifo_write)
    begin
      next_wr_ptr = wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      wr_ptr <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
    end
  end

  // Memory has no reset; the pointers say what is valid
  always_ff @(posedge SYS_CLK)
  begin
    if (a_fifo_write)
    begin
      mem[wr_ptr[AW-1:0]] <= WRITE_PORT_DATA_IN;
    end
  end

  // Read side state
  always_comb
  begin
    next_rd_ptr    = rd_ptr;
    next_out_reg   = out_reg;
    next_out_ready = out_ready;
    if (load_out)
    begin
      next_out_reg = mem[rd_ptr[AW-1:0]];
      next_rd_ptr  = rd_ptr + 1'b1;
    end
    if (FALL_THROUGH_MODE)
    begin
      if (load_out)
      begin
        next_out_ready = 1'b1;
      end
      // A read with nothing behind it drops ready
      else if (read_ok)
      begin
        next_out_ready = 1'b0;
      end
    end
    else
    begin
      next_out_ready = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      rd_ptr    <= '0;
      out_reg   <= DATA_RESET;
      out_ready <= OUT_READY_RESET;
    end
    else
    begin
      rd_ptr    <= next_rd_ptr;
      out_reg   <= next_out_reg;
      out_ready <= next_out_ready;
    end
  end

  // Flag levels; mode and offsets are held static by the system
  // Full side from write-side fill, empty side from read-side fill
  assign EMPTY_OR_OUT_READY = FALL_THROUGH_MODE ? out_ready : empty_n_std;
  assign ALMOST_EMPTY_N     = fill_rd > {1'b0, ALMOST_EMPTY_OFFSET};
  assign ALMOST_FULL_N      = fill_wr < (DEPTH_WORDS - {1'b0, ALMOST_FULL_OFFSET});
  assign FULL_OR_IN_READY   = fill_wr != DEPTH_WORDS;

endmodule
`default_nettype wire

// file: dv/dcf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcf_host_model
(
  input  wire logic        clk,
  input  wire logic        host_oe,
  input  wire logic [35:0] host_val,
  input  wire logic        dut_oe_n,
  input  wire logic [35:0] dut_val,
  output logic      [35:0] bus
);
  logic [35:0] last;
  // Undriven bus flips each cycle
  always_comb
  begin
    if (host_oe)
      bus = host_val;
    else if (!dut_oe_n)
      bus = dut_val;
    else
      bus = ~last;
  end
  always_ff @(posedge clk)
    last <= bus;
endmodule
`default_nettype wire

// file: dv/dcf_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module dcf_top_asserts
#(
  parameter int unsigned DEPTH = 2048
)
(
  input wire logic                    SYS_CLK,
  input wire logic                    SYS_RST,
  input wire logic                    FALL_THROUGH_MODE,
  input wire dcf_pkg::dcf_port_ctrl_t WRITE_PORT_CTRL,
  input wire dcf_pkg::dcf_port_ctrl_t READ_PORT_CTRL,
  input wire logic [35:0]             READ_PORT_DATA_OUT,
  input wire logic                    WRITE_PORT_DATA_OE_N,
  input wire logic                    READ_PORT_DATA_OE_N,
  input wire logic                    FULL_OR_IN_READY,
  input wire logic                    ALMOST_FULL_N,
  input wire logic                    EMPTY_OR_OUT_READY,
  input wire logic                    ALMOST_EMPTY_N,
  input wire logic                    A_TO_B_MAIL_FLAG_N,
  input wire logic                    B_TO_A_MAIL_FLAG_N
);
  import dcf_pkg::*;
  logic [3:0] ca;
  logic [3:0] cb;
  assign ca = WRITE_PORT_CTRL;
  assign cb = READ_PORT_CTRL;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  property p_a_oe; WRITE_PORT_DATA_OE_N == (ca[3] | ca[2]); endproperty
  a_a_oe: assert property (p_a_oe) else $error("port A drive");
  property p_b_oe; READ_PORT_DATA_OE_N == (cb[3] | !cb[2]); endproperty
  a_b_oe: assert property (p_b_oe) else $error("port B drive");
  property p_mb2_rd; ca == 4'h3 && cb != 4'h3 |=> B_TO_A_MAIL_FLAG_N; endproperty
  a_mb2_rd: assert property (p_mb2_rd) else $error("b_to_a_mailbox flag set");
  property p_mb1_rd; cb == 4'h7 && ca != 4'h7 |=> A_TO_B_MAIL_FLAG_N; endproperty
  a_mb1_rd: assert property (p_mb1_rd) else $error("a_to_b_mailbox flag set");
  property p_mb1_wr; ca == 4'h7 && cb != 4'h7 |-> ##1 !A_TO_B_MAIL_FLAG_N; endproperty
  a_mb1_wr: assert property (p_mb1_wr) else $error("a_to_b_mailbox flag clear");
  property p_mb2_hold; !B_TO_A_MAIL_FLAG_N && ca != 4'h3 |=> !B_TO_A_MAIL_FLAG_N; endproperty
  a_mb2_hold: assert property (p_mb2_hold) else $error("b_to_a_mailbox flag hold");
  property p_ef_std;
    $rose(EMPTY_OR_OUT_READY) && !FALL_THROUGH_MODE |-> $past(ca, 3) == 4'h6;
  endproperty
  a_ef_std: assert property (p_ef_std) else $error("empty rise time");
  property p_or_ft;
    $rose(EMPTY_OR_OUT_READY) && FALL_THROUGH_MODE |-> $past(ca, 4) == 4'h6;
  endproperty
  a_or_ft: assert property (p_or_ft) else $error("ready rise time");
  property p_std_hold;
    (!FALL_THROUGH_MODE && !EMPTY_OR_OUT_READY && cb == 4'h6 ##1 !cb[0])
      |-> $stable(READ_PORT_DATA_OUT);
  endproperty
  a_std_hold: assert property (p_std_hold) else $error("empty read");
  property p_full_af; !FULL_OR_IN_READY |-> !ALMOST_FULL_N; endproperty
  a_full_af: assert property (p_full_af) else $error("full vs af");
  property p_ae_ef;
    ALMOST_EMPTY_N && !FALL_THROUGH_MODE |-> EMPTY_OR_OUT_READY;
  endproperty
  a_ae_ef: assert property (p_ae_ef) else $error("ae vs empty");
endmodule
bind dcf_top dcf_top_asserts #(.DEPTH(DEPTH)) u_chk (.SYS_CLK, .SYS_RST, .FALL_THROUGH_MODE,
  .WRITE_PORT_CTRL, .READ_PORT_CTRL, .READ_PORT_DATA_OUT, .WRITE_PORT_DATA_OE_N,
  .READ_PORT_DATA_OE_N, .FULL_OR_IN_READY, .ALMOST_FULL_N, .EMPTY_OR_OUT_READY,
  .ALMOST_EMPTY_N, .A_TO_B_MAIL_FLAG_N, .B_TO_A_MAIL_FLAG_N);
`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dcf_pkg::*;
  logic           clk, rst, ft, ea, eb, full, afull, empty, aempty, f1, f2;
  dcf_port_ctrl_t ca, cb;
  logic [35:0]    ha, hb, qa, qb, oa, ob;
  int             n_fail, tests_run;
  localparam logic [35:0] W = 36'ha_5a5a_0000;
  dcf_top dut (.SYS_CLK(clk), .SYS_RST(rst), .FALL_THROUGH_MODE(ft),
    .ALMOST_EMPTY_OFFSET(11'h004), .ALMOST_FULL_OFFSET(11'h004),
    .WRITE_PORT_CTRL(ca), .WRITE_PORT_DATA_IN(qa), .WRITE_PORT_DATA_OUT(oa),
    .WRITE_PORT_DATA_OE_N(ea), .READ_PORT_CTRL(cb), .READ_PORT_DATA_IN(qb),
    .READ_PORT_DATA_OUT(ob), .READ_PORT_DATA_OE_N(eb), .FULL_OR_IN_READY(full),
    .ALMOST_FULL_N(afull), .EMPTY_OR_OUT_READY(empty), .ALMOST_EMPTY_N(aempty),
    .A_TO_B_MAIL_FLAG_N(f1), .B_TO_A_MAIL_FLAG_N(f2));
  dcf_host_model pa (.clk(clk), .host_oe(ca.enable & ea), .host_val(ha),
    .dut_oe_n(ea), .dut_val(oa), .bus(qa));
  dcf_host_model pb (.clk(clk), .host_oe(cb.enable & eb), .host_val(hb),
    .dut_oe_n(eb), .dut_val(ob), .bus(qb));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic op(input logic [3:0] a, input logic [3:0] b, input logic [35:0] d);
    @(posedge clk);
    ca <= a;
    cb <= b;
    ha <= d;
    hb <= d;
    #1;
  endtask
  task automatic hold(input int n);
    repeat (n) op(4'h8, 4'h4, 36'h0);
  endtask
  task automatic rstp(input logic m);
    @(posedge clk);
    rst <= 1'b1;
    ft <= m;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #60us;
    n_fail++;
    summarize();
  end
  initial
  begin
    {rst, ft, ca, cb, ha, hb, n_fail, tests_run} = {2'b10, 8'h88, 72'h0, 64'h0};
    rstp(1'b0);
    chk("flags", 36'h33, 36'({full, afull, empty, aempty, f1, f2}));
    op(4'h7, 4'h4, 36'h1_2345_6789);
    op(4'h7, 4'h4, 36'h0_dead_beef);
    chk("a_to_b_mailbox flag", 36'h0, 36'(f1));
    op(4'h8, 4'h7, 36'h0);
    chk("a_to_b_mailbox data", 36'h1_2345_6789, qb);
    op(4'h8, 4'h3, 36'h2_0000_00a5);
    chk("a_to_b_mailbox flag", 36'h1, 36'(f1));
    op(4'h3, 4'h4, 36'h0);
    chk("b_to_a_mailbox flag", 36'h0, 36'(f2));
    chk("b_to_a_mailbox data", 36'h2_0000_00a5, qa);
    hold(1);
    chk("b_to_a_mailbox flag", 36'h1, 36'(f2));
    op(4'h5, 4'h1, 36'h0_0000_0bad);
    op(4'h2, 4'h2, 36'h0_0000_0bad);
    hold(1);
    chk("idle mail flags", 36'h3, 36'({f1, f2}));
    $display("test mailbox done");
    op(4'h6, 4'h4, W);
    hold(2);
    chk("empty", 36'h0, 36'(empty));
    hold(1);
    chk("empty", 36'h1, 36'(empty));
    for (int i = 1; i < 5; i++)
      op(4'h6, 4'h4, W + 36'(i));
    hold(2);
    chk("almost empty", 36'h0, 36'(aempty));
    hold(1);
    chk("almost empty", 36'h1, 36'(aempty));
    for (int i = 0; i < 6; i++)
    begin
      op(4'h8, 4'h6, 36'h0);
      if (i > 0)
        chk("fifo data", W + 36'(i - 1), qb);
    end
    hold(1);
    chk("empty read", W + 36'h4, qb);
    chk("empty", 36'h0, 36'(empty));
    for (int i = 0; i < 2048; i++)
      op(4'h6, 4'h4, 36'(i));
    op(4'h6, 4'h4, 36'hf);
    chk("full", 36'h0, 36'({full, afull}));
    op(4'h8, 4'h6, 36'h0);
    hold(2);
    chk("first word", 36'h0, qb);
    chk("full", 36'h0, 36'(full));
    hold(1);
    chk("full", 36'h1, 36'(full));
    $display("test standard done");
    rstp(1'b1);
    op(4'h6, 4'h4, W);
    hold(3);
    chk("ready", 36'h0, 36'(empty));
    hold(1);
    chk("ready", 36'h1, 36'(empty));
    chk("auto word", W, qb);
    op(4'h6, 4'h4, W + 36'h1);
    hold(4);
    chk("no auto", W, qb);
    for (int i = 0; i < 3; i++)
    begin
      op(4'h8, 4'h6, 36'h0);
      hold(1);
      chk("ft data", W + 36'h1, qb);
      chk("ready", 36'(i == 0), 36'(empty));
    end
    $display("test fall through done");
    summarize();
  end
endmodule
`default_nettype wire
